// File: asrc_pkg.sv
// Shared constants for the stereo sample rate converter core
package asrc_pkg;
  localparam int MCLK_HZ = 50_000_000;
  localparam int MCLK_PERIOD_PS = 20_000;
  localparam int MASTER_HZ = 16_000_000;
  localparam int MASTER_PERIOD_PS = 62_500;
  // Least time resolved between clock events, rounded up to mclk cycles
  localparam int MASTER_CYCLES = (MASTER_PERIOD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int SYNC_STAGES = 3;
  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam int FRAC_W = 16;
  localparam int SUBFILTERS = 65536;
  localparam int RATIO_W = 18;
  localparam logic [4:0] TARGET_FILL = 5'h05;
  localparam logic [1:0] MAX_ADVANCE = 2'h2;
  localparam logic [RATIO_W-1:0] RATIO_UNITY = 18'h10000;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 18'h20000;
  localparam int TRIM_POS = 12;
  localparam int SLOW_CORNER_HZ = 3;
  localparam int FAST_CORNER_HZ = 12;
  localparam int ROLLOFF_DB_PER_OCTAVE = 6;
  localparam int SLOW_SETTLE_MS = 800;
  localparam int FAST_SETTLE_MS = 200;
  localparam longint SLOW_SETTLE_CYC = longint'(SLOW_SETTLE_MS) * (MCLK_HZ / 1000);
  localparam longint FAST_SETTLE_CYC = longint'(FAST_SETTLE_MS) * (MCLK_HZ / 1000);
  // Corner ratio 12/3 = 4 means two more bits of smoothing in slow mode
  localparam logic [3:0] FAST_SHIFT = 4'h6;
  localparam logic [3:0] SLOW_SHIFT = 4'h8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_POP = 2'b01,
    ST_EMIT = 2'b11
  } rd_state_t;
endpackage : asrc_pkg

// File: sample_fifo.sv
// Input sample FIFO with a write address counter and valid/ready on both sides
`timescale 1ns/10ps
module sample_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic wrValid,
  input wire logic [WIDTH-1:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [WIDTH-1:0] rdData,
  input wire logic rdReady,
  output logic [AW:0] fill,
  output logic [AW-1:0] wrAddr,
  output logic [AW-1:0] rdAddr
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic doWrite;
  logic doRead;

  assign wrReady = (fill != (AW+1)'(DEPTH));
  assign rdValid = (fill != '0);
  assign rdData = mem[rdAddr];
  assign doWrite = wrValid && wrReady;
  assign doRead = rdValid && rdReady;

  always_ff @(posedge mclk) begin
    if (doWrite) begin
      mem[wrAddr] <= wrData;
    end
  end

  // Write address steps once per stored stereo frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wrAddr <= '0;
    end else if (doWrite) begin
      wrAddr <= (wrAddr == AW'(DEPTH - 1)) ? '0 : wrAddr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdAddr <= '0;
    end else if (doRead) begin
      rdAddr <= (rdAddr == AW'(DEPTH - 1)) ? '0 : rdAddr + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fill <= '0;
    end else if (doWrite && !doRead) begin
      fill <= fill + 1'b1;
    end else if (doRead && !doWrite) begin
      fill <= fill - 1'b1;
    end
  end

  AST_WR_ADVANCE: assert property (@(posedge mclk) disable iff (!rst_n)
    doWrite && wrAddr != AW'(DEPTH - 1) |=> wrAddr == $past(wrAddr) + 1'b1)
    else $error("write address did not advance on a stored frame");
endmodule : sample_fifo

// File: asrc_core.sv
// Servo loop, phase selection and read control of the sample rate converter
`timescale 1ns/10ps
module asrc_core
  import asrc_pkg::*;
#(
  parameter longint SLOW_SETTLE_CYCLES = SLOW_SETTLE_CYC,
  parameter longint FAST_SETTLE_CYCLES = FAST_SETTLE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inputFrameClock,
  input wire logic outputFrameClock,
  input wire logic settleSlowSelect,
  input wire logic muteRequest,
  input wire logic [asrc_pkg::SAMPLE_W-1:0] inLeft,
  input wire logic [asrc_pkg::SAMPLE_W-1:0] inRight,
  output logic inReady,
  output logic muteStatus,
  output logic ratioSettled,
  output logic outValid,
  output logic [asrc_pkg::SAMPLE_W-1:0] outLeft,
  output logic [asrc_pkg::SAMPLE_W-1:0] outRight,
  output logic [asrc_pkg::FIFO_AW-1:0] fifoReadStart,
  output logic [asrc_pkg::FIFO_AW-1:0] fifoWriteAddr,
  output logic [asrc_pkg::FRAC_W-1:0] coefStart,
  output logic [asrc_pkg::RATIO_W-1:0] ratio
);
  import asrc_pkg::*;

  localparam int NPIN = 4;

  logic [1:0] rstPipe;
  logic rstSync_n;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] sync1;
  logic [NPIN-1:0] sync2;
  logic [NPIN-1:0] sync3;
  logic [NPIN-1:0] level;
  logic [NPIN-1:0] levelDly;
  logic inEvt;
  logic outEvt;
  logic settleSlow;
  logic muteReq;
  logic fifoRdValid;
  logic fifoRdReady;
  logic [2*SAMPLE_W-1:0] fifoRdData;
  logic [FIFO_AW:0] fill;
  logic overflow;
  logic underflow;
  logic [1:0] inCount;
  logic [3:0] activeShift;
  logic signed [RATIO_W+1:0] ratioDiff;
  logic signed [RATIO_W+1:0] next_ratio;
  logic signed [RATIO_W+1:0] fillErr;
  logic signed [RATIO_W+1:0] stepRaw;
  logic [RATIO_W-1:0] step;
  logic [FRAC_W-1:0] phaseFrac;
  logic [RATIO_W-1:0] phaseSum;
  logic [1:0] advance;
  logic [1:0] pending;
  rd_state_t state;
  logic [SAMPLE_W-1:0] holdLeft;
  logic [SAMPLE_W-1:0] holdRight;
  logic [25:0] settleCount;
  logic [25:0] settleLimit;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  assign rstSync_n = rstPipe[1];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign pins = {muteRequest, settleSlowSelect, outputFrameClock, inputFrameClock};

  // Only stable agreement of the last two stages counts, so a runt pulse
  // on a frame clock cannot fake a sample event
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      level <= '0;
      levelDly <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < NPIN; i++) begin
        if (sync2[i] == sync3[i]) begin
          level[i] <= sync3[i];
        end
      end
      levelDly <= level;
    end
  end

  assign inEvt = level[0] && !levelDly[0];
  assign outEvt = level[1] && !levelDly[1];
  assign settleSlow = level[2];
  assign muteReq = level[3];

  AST_EVENT_PULSE: assert property (@(posedge mclk) disable iff (!rstSync_n)
    inEvt |=> !inEvt)
    else $error("input frame event lasted more than one cycle");

  //////////////////////////////////////////////////////////////////////////////
  // Input sample FIFO

  sample_fifo #(
    .WIDTH(2 * SAMPLE_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .rst_n(rstSync_n),
    .wrValid(inEvt),
    .wrData({inLeft, inRight}),
    .wrReady(inReady),
    .rdValid(fifoRdValid),
    .rdData(fifoRdData),
    .rdReady(fifoRdReady),
    .fill(fill),
    .wrAddr(fifoWriteAddr),
    .rdAddr(fifoReadStart)
  );

  // Write pointer running into the read pointer, or a read past the write
  assign overflow = inEvt && !inReady;
  assign underflow = (state == ST_POP) && (pending != 2'h0) && !fifoRdValid;

  // Set wins over the clear; recovery waits for the nominal spacing again
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      muteStatus <= 1'b0;
    end else if (overflow || underflow) begin
      muteStatus <= 1'b1;
    end else if (fill == TARGET_FILL) begin
      muteStatus <= 1'b0;
    end
  end

  AST_MUTE_ON_CROSS: assert property (@(posedge mclk) disable iff (!rstSync_n)
    overflow || underflow |=> muteStatus)
    else $error("pointer crossing did not raise mute status");

  //////////////////////////////////////////////////////////////////////////////
  // Servo loop: ratio estimate from both clocks' past events

  // Input events seen during the current output period, saturating
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      inCount <= 2'h0;
    end else if (outEvt) begin
      inCount <= {1'b0, inEvt};
    end else if (inEvt && inCount != 2'h3) begin
      inCount <= inCount + 2'h1;
    end
  end

  // Loop gain is latched only at an output event, so a pin change never
  // splits one update between two gains
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      activeShift <= SLOW_SHIFT;
    end else if (outEvt) begin
      activeShift <= settleSlow ? SLOW_SHIFT : FAST_SHIFT;
    end
  end

  AST_SHIFT_HOLD: assert property (@(posedge mclk) disable iff (!rstSync_n)
    !outEvt |=> $stable(activeShift))
    else $error("loop gain changed outside an output event");

  AST_SHIFT_SELECT: assert property (@(posedge mclk) disable iff (!rstSync_n)
    outEvt |=> activeShift == ($past(settleSlow) ? SLOW_SHIFT : FAST_SHIFT))
    else $error("settle select picked the wrong loop gain");

  // One-pole smoothing: ratio += (measured - ratio) / 2^shift, 6 dB/octave
  always_comb begin
    ratioDiff = $signed({2'b00, inCount, FRAC_W'(0)}) - $signed({2'b00, ratio});
    next_ratio = $signed({2'b00, ratio}) + (ratioDiff >>> activeShift);
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ratio <= RATIO_UNITY;
    end else if (outEvt) begin
      ratio <= next_ratio[RATIO_W-1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Settling indicator: quiet time after reset, a mode switch or a FIFO overflow/underflow

  assign settleLimit = settleSlow ? 26'(SLOW_SETTLE_CYCLES) : 26'(FAST_SETTLE_CYCLES);

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      settleCount <= '0;
    end else if (level[2] != levelDly[2] || overflow || underflow) begin
      settleCount <= '0;
    end else if (settleCount < settleLimit) begin
      settleCount <= settleCount + 26'h1;
    end
  end

  assign ratioSettled = (settleCount >= settleLimit);

  //////////////////////////////////////////////////////////////////////////////
  // Phase accumulator: read advance and subfilter selection

  // A fill above target reads slightly faster, below slightly slower,
  // which pulls the spacing back to its nominal value
  always_comb begin
    fillErr = $signed({{(RATIO_W+1-FIFO_AW){1'b0}}, fill}) - $signed(20'(TARGET_FILL));
    stepRaw = $signed({2'b00, ratio}) + (fillErr <<< TRIM_POS);
    if (stepRaw < 0) begin
      step = '0;
    end else if (stepRaw > $signed({2'b00, RATIO_MAX})) begin
      step = RATIO_MAX;
    end else begin
      step = stepRaw[RATIO_W-1:0];
    end
    phaseSum = {2'b00, phaseFrac} + step;
    advance = (phaseSum[RATIO_W-1:FRAC_W] > MAX_ADVANCE) ? MAX_ADVANCE :
      phaseSum[RATIO_W-1:FRAC_W];
  end

  // Fraction is how far into the input period the request falls: a late
  // request gives a large offset, i.e. a short filter delay
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phaseFrac <= '0;
      coefStart <= '0;
    end else if (outEvt) begin
      phaseFrac <= phaseSum[FRAC_W-1:0];
      coefStart <= phaseSum[FRAC_W-1:0];
    end
  end

  AST_COEF_ONLY_AT_EVENT: assert property (@(posedge mclk) disable iff (!rstSync_n)
    !outEvt |=> $stable(coefStart))
    else $error("coefficient start moved without an output event");

  //////////////////////////////////////////////////////////////////////////////
  // Read control: consume 0..2 samples, then emit one output

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state <= ST_IDLE;
      pending <= 2'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (outEvt) begin
            pending <= advance;
            state <= ST_POP;
          end
        end
        ST_POP: begin
          if (pending == 2'h0 || !fifoRdValid) begin
            pending <= 2'h0;
            state <= ST_EMIT;
          end else begin
            pending <= pending - 2'h1;
          end
        end
        ST_EMIT: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Every owed sample is taken once unless the FIFO runs empty; rate differences live in the phase
  assign fifoRdReady = (state == ST_POP) && (pending != 2'h0);

  AST_ADVANCE_MAX: assert property (@(posedge mclk) disable iff (!rstSync_n)
    state == ST_IDLE && outEvt |=> pending <= MAX_ADVANCE)
    else $error("read start advanced by more than two samples");

  AST_NO_DROP: assert property (@(posedge mclk) disable iff (!rstSync_n)
    state == ST_POP && pending == 2'h2 && fifoRdValid |=> fifoRdReady || underflow)
    else $error("owed input sample not consumed");

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      holdLeft <= '0;
      holdRight <= '0;
    end else if (fifoRdReady && fifoRdValid) begin
      holdLeft <= fifoRdData[2*SAMPLE_W-1:SAMPLE_W];
      holdRight <= fifoRdData[SAMPLE_W-1:0];
    end
  end

  // The convolver is outside; this stage hands it the newest read sample
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      outValid <= 1'b0;
      outLeft <= '0;
      outRight <= '0;
    end else begin
      outValid <= (state == ST_EMIT);
      if (state == ST_EMIT) begin
        outLeft <= muteReq ? '0 : holdLeft;
        outRight <= muteReq ? '0 : holdRight;
      end
    end
  end

  AST_EMIT_AFTER_EVENT: assert property (@(posedge mclk) disable iff (!rstSync_n)
    state == ST_IDLE && outEvt |-> ##[3:5] outValid)
    else $error("output event produced no output sample");

  AST_MUTE_ZERO: assert property (@(posedge mclk) disable iff (!rstSync_n)
    outValid && $past(muteReq) |-> outLeft == '0 && outRight == '0)
    else $error("muted output carried non-zero data");

endmodule : asrc_core

// File: frame_source.sv
// Far-side model: free-running input and output frame clocks with stereo samples
`timescale 1ns/10ps
module frame_source
  import asrc_pkg::*;
(
  input wire logic mclk,
  input wire logic [15:0] inHalf,
  input wire logic [15:0] outHalf,
  input wire logic outRun,
  output logic inputFrameClock,
  output logic outputFrameClock,
  output logic [asrc_pkg::SAMPLE_W-1:0] inLeft,
  output logic [asrc_pkg::SAMPLE_W-1:0] inRight
);
  logic [15:0] inCnt = 16'h0;
  logic [15:0] outCnt = 16'h0;
  logic [15:0] seq = 16'h0;
  initial begin
    inputFrameClock = 1'b0;
    outputFrameClock = 1'b0;
  end
  // Right is the inverse of left, so a mixed-up pair shows at once
  assign inLeft = seq;
  assign inRight = ~seq;
  // Falling mclk edges keep every pin change well away from the core's sampling edge
  always @(negedge mclk) begin
    inCnt <= (inCnt + 16'h1 >= inHalf) ? 16'h0 : inCnt + 16'h1;
    if (inCnt + 16'h1 >= inHalf) begin
      inputFrameClock <= ~inputFrameClock;
      // New sample only on the low-going edge: held over the whole high phase
      if (inputFrameClock) begin
        seq <= seq + 16'h1;
      end
    end
    // Stopping the output clock is how a scenario overfills the FIFO
    if (outRun) begin
      outCnt <= (outCnt + 16'h1 >= outHalf) ? 16'h0 : outCnt + 16'h1;
      if (outCnt + 16'h1 >= outHalf) begin
        outputFrameClock <= ~outputFrameClock;
      end
    end
  end
endmodule : frame_source

// File: asrc_core_tb.sv
// Self-checking bench for the sample rate converter core
`timescale 1ns/10ps
module asrc_core_tb;
  import asrc_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic settleSlowSelect = 1'b0;
  logic muteRequest = 1'b0;
  logic [15:0] inHalf = 16'h0064;
  logic [15:0] outHalf = 16'h0064;
  logic outRun = 1'b1;
  logic inputFrameClock, outputFrameClock, inReady, muteStatus, ratioSettled, outValid;
  logic [SAMPLE_W-1:0] inLeft, inRight, outLeft, outRight;
  logic [FIFO_AW-1:0] fifoReadStart, fifoWriteAddr;
  logic [FRAC_W-1:0] coefStart;
  logic [RATIO_W-1:0] ratio;
  int miscompares = 0;
  int checks_done = 0;
  always #10 mclk = ~mclk;
  frame_source u_frame_source (.mclk(mclk), .inHalf(inHalf), .outHalf(outHalf),
    .outRun(outRun), .inputFrameClock(inputFrameClock),
    .outputFrameClock(outputFrameClock), .inLeft(inLeft), .inRight(inRight));
  asrc_core #(.SLOW_SETTLE_CYCLES(400), .FAST_SETTLE_CYCLES(100)) u_asrc_core (
    .mclk(mclk), .rst_n(rst_n), .inputFrameClock(inputFrameClock),
    .outputFrameClock(outputFrameClock), .settleSlowSelect(settleSlowSelect),
    .muteRequest(muteRequest), .inLeft(inLeft), .inRight(inRight), .inReady(inReady),
    .muteStatus(muteStatus), .ratioSettled(ratioSettled), .outValid(outValid),
    .outLeft(outLeft), .outRight(outRight), .fifoReadStart(fifoReadStart),
    .fifoWriteAddr(fifoWriteAddr), .coefStart(coefStart), .ratio(ratio));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // Any wait that uses up its bound ends the run
  task automatic guard(input int n, input int limit);
    if (n >= limit) begin
      check(32'h0, 32'h1);
      summarize();
    end
  endtask : guard
  task automatic waitOut();
    int n;
    n = 0;
    @(negedge mclk);
    while (outValid !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 2000);
  endtask : waitOut
  task automatic waitInRise();
    int n;
    n = 0;
    while (inputFrameClock !== 1'b0 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    while (inputFrameClock !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 1000);
  endtask : waitInRise
  ////////////////////////////////////////////////////////////////////////////////
  task automatic testWriteAddr();
    logic [FIFO_AW-1:0] a;
    // Sample the address only once the write of the last event has landed
    waitInRise();
    repeat (12) @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      a = fifoWriteAddr;
      waitInRise();
      repeat (12) @(negedge mclk);
      check(fifoWriteAddr, 4'(a + 4'h1));
    end
  endtask : testWriteAddr
  task automatic testStream();
    logic [FIFO_AW-1:0] r;
    logic [FIFO_AW-1:0] d;
    logic [FRAC_W-1:0] c;
    int pos;
    waitOut();
    for (int i = 0; i < 20; i++) begin
      r = fifoReadStart;
      c = coefStart;
      waitOut();
      d = fifoReadStart - r;
      check(d <= 4'(MAX_ADVANCE), 1);
      // Whole samples read plus the subfilter offset move by about one input period
      pos = int'(d) * 32'h10000 + int'(coefStart) - int'(c);
      check(pos >= 32'h8000 && pos <= 32'h18000, 1);
      check(outRight, 16'(~outLeft));
      check(muteStatus, 1'b0);
    end
    d = fifoWriteAddr - fifoReadStart;
    check(d >= 4'h3 && d <= 4'h7, 1);
  endtask : testStream
  task automatic testMute();
    muteRequest = 1'b1;
    waitOut();
    repeat (2) begin
      waitOut();
      check({outLeft, outRight}, 32'h0);
    end
    muteRequest = 1'b0;
    waitOut();
    waitOut();
    check(outRight, 16'(~outLeft));
  endtask : testMute
  task automatic testRatio();
    inHalf = 16'h0050;
    repeat (40) waitOut();
    check(ratio > RATIO_UNITY && ratio <= RATIO_MAX, 1);
    inHalf = 16'h0064;
    repeat (30) waitOut();
  endtask : testRatio
  task automatic testSettle();
    int n;
    waitOut();
    settleSlowSelect = 1'b1;
    repeat (350) @(negedge mclk);
    check(ratioSettled, 1'b0);
    n = 0;
    while (ratioSettled !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 1000);
    waitOut();
    settleSlowSelect = 1'b0;
    repeat (330) @(negedge mclk);
    check(ratioSettled, 1'b1);
  endtask : testSettle
  task automatic testOverflow();
    int n;
    outRun = 1'b0;
    n = 0;
    while (inReady !== 1'b0 && n < 6000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 6000);
    // The next write finds no room and must be flagged
    waitInRise();
    waitInRise();
    repeat (12) @(negedge mclk);
    check(muteStatus, 1'b1);
    outRun = 1'b1;
    n = 0;
    while (muteStatus !== 1'b0 && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 30000);
    check(inReady, 1'b1);
  endtask : testOverflow
  task automatic testUnderflow();
    int n;
    // Input clock held still, so the read side runs the FIFO dry
    inHalf = 16'hffff;
    n = 0;
    while (muteStatus !== 1'b1 && n < 8000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 8000);
    check(fifoReadStart, fifoWriteAddr);
    check(ratio < RATIO_UNITY, 1);
    inHalf = 16'h0064;
    n = 0;
    while (muteStatus !== 1'b0 && n < 30000) begin
      @(negedge mclk);
      n++;
    end
    guard(n, 30000);
    check(inReady, 1'b1);
  endtask : testUnderflow
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge mclk);
    check(ratio, RATIO_UNITY);
    check({inReady, muteStatus, outValid, ratioSettled}, 4'h8);
    check({fifoReadStart, fifoWriteAddr, coefStart}, 24'h0);
    @(negedge mclk);
    rst_n = 1'b1;
    repeat (20) @(negedge mclk);
    testWriteAddr();
    testStream();
    testMute();
    testRatio();
    testSettle();
    testOverflow();
    testUnderflow();
    summarize();
  end
endmodule : asrc_core_tb
